// ### core/snp_cache_mem.sv
// Page cache memory: one write port, one read port, registered read data.
// Assumes write and read ports share the system clock.
`timescale 1ns/1ps
module snp_cache_mem #(
	parameter int DW = 8,
	parameter int DEPTH = 2176,
	parameter int AW = 12
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// Read port
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [DEPTH]; // Byte storage

	// Write without clearing other bytes
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read, out of range reads as erased
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else if (int'(raddr) < DEPTH) begin
			rdata <= mem[raddr];
		end else begin
			rdata <= '1;
		end
	end
endmodule

// ### core/snp_core.sv
// Serial NAND command sequencer: program, data move, erase, reset, OTP and
// block protection. Assumes the serial pins arrive asynchronously and the
// serial clock is well below a quarter of the system clock.
`timescale 1ns/1ps
module snp_core
	import snp_pkg::*;
#(
	parameter int unsigned PROG_CYC =
		(PROG_TIME_US * 1000 + CLK_NS - 1) / CLK_NS,
	parameter int unsigned ERASE_CYC =
		(ERASE_TIME_US * 1000 + CLK_NS - 1) / CLK_NS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Serial link
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic serial_line0_i,
	output logic serial_line0_o,
	output logic serial_line0_oe,
	input wire logic serial_line1_i,
	output logic serial_line1_o,
	output logic serial_line1_oe,
	input wire logic serial_line2_i,
	output logic serial_line2_o,
	output logic serial_line2_oe,
	input wire logic serial_line3_i,
	output logic serial_line3_o,
	output logic serial_line3_oe,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	snp_state_t s_q; // Registered state
	snp_state_t s_d; // Next state
	logic [7:0] mem_rdata; // Cache byte at current column

	////////////////////////////////////////////////////////////////////////
	// Protection range decode
	function automatic logic row_locked(input logic [16:0] r,
		input logic [7:0] p);
		logic [2:0] bp;
		logic [16:0] span;
		logic base;
		bp = p[5:3];
		span = RANGE_UNIT << (bp - 3'd1);
		base = p[LOWER_BIT] ? (r < span) : (r >= 17'(17'h0 - span));
		if (bp == 3'd0) begin
			return 1'b0;
		end
		if (bp == 3'd7) begin
			return 1'b1;
		end
		if (p[COMPL_BIT] && bp == 3'd6) begin
			return r[16:6] == 11'h000;
		end
		return p[COMPL_BIT] ? !base : base;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Cache memory
	snp_cache_mem #(
		.DW(8),
		.DEPTH(CACHE_DEPTH),
		.AW(12)
	) u_cache (
		.clk(clk),
		.rst(rst),
		.we(s_q.mem_we),
		.waddr(s_q.mem_wa),
		.wdata(s_q.mem_wd),
		.raddr(s_q.col),
		.rdata(mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic rise;
		logic fall;
		logic busy;
		logic [7:0] byte_in;
		logic [7:0] feat;
		logic [7:0] status;
		logic [7:0] take;
		logic [7:0] din;
		logic [23:0] nxt;
		logic [11:0] last_col;
		logic [3:0] sum;
		rise = 1'b0;
		fall = 1'b0;
		busy = 1'b0;
		byte_in = '0;
		feat = '0;
		status = '0;
		take = '0;
		din = '0;
		nxt = '0;
		last_col = '0;
		sum = '0;
		s_d = s_q;
		s_d.mem_we = 1'b0;

		// Pin synchronisers and edge detection
		s_d.cs_s = {s_q.cs_s[0], cs_n};
		s_d.sck_s = {s_q.sck_s[0], sclk};
		s_d.sck_prev = s_q.sck_s[1];
		s_d.ln_m = {serial_line3_i, serial_line2_i, serial_line1_i,
			serial_line0_i};
		s_d.ln_s = s_q.ln_m;
		rise = s_q.sck_s[1] & ~s_q.sck_prev;
		fall = ~s_q.sck_s[1] & s_q.sck_prev;
		busy = s_q.op != OP_IDLE;
		last_col = s_q.ecc ? LAST_COL_ECC : LAST_COL_RAW;

		// Status and feature bytes, read in real time
		status = {4'h0, s_q.pfail, s_q.efail, s_q.write_latch, busy};
		unique case (s_q.fadr)
			FA_PROT: feat = s_q.prot & PROT_MASK;
			FA_CFG: feat = {s_q.prt_req | s_q.otp_locked, s_q.otp_en,
				1'b0, s_q.ecc, 3'b000, s_q.quad};
			FA_STAT: feat = status;
			FA_DRV: feat = {1'b0, s_q.drv, 5'h00};
			default: feat = '0;
		endcase

		// Wishbone slave: one wait state, unmapped reads zero
		s_d.wb_ack = wb_cyc_i & wb_stb_i & ~s_q.wb_ack;
		if (wb_cyc_i && wb_stb_i && !s_q.wb_ack) begin
			unique case ({wb_adr_i[7:2], 2'b00})
				REG_STATUS: s_d.wb_dat = {24'h000000, status};
				REG_FEAT: s_d.wb_dat = {8'h00, s_q.drv, 6'h00,
					s_q.prt_req | s_q.otp_locked, s_q.otp_en, 1'b0,
					s_q.ecc, 3'b000, s_q.quad, s_q.prot & PROT_MASK};
				REG_ROW: s_d.wb_dat = {15'h0000, s_q.row};
				REG_CTRL: s_d.wb_dat = {31'h00000000, s_q.otp_locked};
				REG_OPINFO: s_d.wb_dat = {7'h00, s_q.op, s_q.cnt};
				default: s_d.wb_dat = '0;
			endcase
			// Power-on OTP lock state, can only be set
			if (wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == REG_CTRL[7:2]
				&& wb_dat_i[0]) begin
				s_d.otp_locked = 1'b1;
			end
		end

		// Internal operation timer
		if (busy) begin
			if (s_q.cnt == '0) begin
				if (s_q.op == OP_PROG || s_q.op == OP_ERASE) begin
					s_d.write_latch = 1'b0;
				end
				s_d.op = OP_IDLE;
			end else begin
				s_d.cnt = s_q.cnt - 20'd1;
			end
		end

		// Serial input sampling by lane width
		unique case (s_q.lanes)
			3'd4: byte_in = {s_q.sh[3:0], s_q.ln_s};
			3'd2: byte_in = {s_q.sh[5:0], s_q.ln_s[1:0]};
			default: byte_in = {s_q.sh[6:0], s_q.ln_s[0]};
		endcase
		sum = s_q.bcnt + 4'(s_q.lanes);
		nxt = {s_q.addr[15:0], byte_in};

		if (s_q.cs_s[1]) begin
			// Deselected: frame ends, release the lines
			s_d.ph = PH_OPC;
			s_d.bcnt = '0;
			s_d.lanes = 3'd1;
			s_d.ocnt = '0;
			s_d.doe = '0;
		end else if (rise && (s_q.ph == PH_OPC || s_q.ph == PH_HEAD
			|| s_q.ph == PH_IN)) begin
			s_d.sh = byte_in;
			s_d.bcnt = (sum == 4'd8) ? 4'd0 : sum;
			if (sum == 4'd8) begin
				unique case (s_q.ph)
					PH_OPC: begin
						s_d.opc = byte_in;
						s_d.ph = PH_SKIP;
						case (byte_in)
							OPC_WREN: begin
								if (!busy) begin
									s_d.write_latch = 1'b1;
								end
							end
							OPC_WRDI: begin
								if (!busy) begin
									s_d.write_latch = 1'b0;
								end
							end
							OPC_RESET: begin
								s_d.op = OP_RST;
								s_d.cnt = 20'(RST_CYC - 1);
								s_d.pfail = 1'b0;
								s_d.efail = 1'b0;
								s_d.write_latch = 1'b0;
								s_d.idm = 1'b0;
							end
							OPC_GETF, OPC_SETF: begin
								s_d.ph = PH_HEAD;
								s_d.hd = 2'd0;
							end
							OPC_PEXE, OPC_PREAD, OPC_ERASE: begin
								if (!busy) begin
									s_d.ph = PH_HEAD;
									s_d.hd = 2'd2;
								end
							end
							OPC_PLOAD: begin
								if (!busy) begin
									s_d.ph = PH_HEAD;
									s_d.hd = 2'd1;
								end
							end
							OPC_PLOAD4: begin
								if (!busy && s_q.quad) begin
									s_d.ph = PH_HEAD;
									s_d.hd = 2'd1;
								end
							end
							OPC_RLOAD, OPC_RLOAD4A, OPC_RLOAD4B: begin
								if (!busy && s_q.idm && (s_q.quad
									|| byte_in == OPC_RLOAD)) begin
									s_d.ph = PH_HEAD;
									s_d.hd = 2'd1;
								end
							end
							OPC_RD, OPC_RDF, OPC_RD2: begin
								s_d.ph = PH_HEAD;
								s_d.hd = 2'd2;
							end
							OPC_RD4: begin
								if (s_q.quad) begin
									s_d.ph = PH_HEAD;
									s_d.hd = 2'd2;
								end
							end
							OPC_RD2IO: begin
								s_d.ph = PH_HEAD;
								s_d.hd = 2'd2;
								s_d.lanes = 3'd2;
							end
							default: s_d.ph = PH_SKIP;
						endcase
					end
					PH_HEAD: begin
						s_d.addr = nxt;
						if (s_q.hd != 2'd0) begin
							s_d.hd = s_q.hd - 2'd1;
						end else begin
							case (s_q.opc)
								OPC_GETF: begin
									s_d.fadr = byte_in;
									s_d.ph = PH_OUT;
									s_d.lanes = 3'd1;
								end
								OPC_SETF: begin
									s_d.fadr = byte_in;
									s_d.ph = PH_IN;
								end
								OPC_PREAD: begin
									s_d.ph = PH_SKIP;
									s_d.row = nxt[16:0];
									s_d.op = OP_READ;
									s_d.cnt = 20'(READ_CYC - 1);
									s_d.idm = 1'b1;
								end
								OPC_PEXE: begin
									s_d.ph = PH_SKIP;
									s_d.row = nxt[16:0];
									if (s_q.write_latch) begin
										s_d.pfail = 1'b0;
										s_d.idm = 1'b0;
										if (s_q.otp_en && s_q.otp_locked) begin
											s_d.pfail = 1'b1;
											s_d.write_latch = 1'b0;
										end else if (s_q.otp_en && s_q.prt_req) begin
											s_d.otp_locked = 1'b1;
											s_d.op = OP_PROG;
											s_d.cnt = 20'(PROG_CYC - 1);
										end else if (s_q.otp_en
											&& nxt[16:0] >= OTP_PAGES) begin
											s_d.pfail = 1'b1;
											s_d.write_latch = 1'b0;
										end else if (!s_q.otp_en
											&& row_locked(nxt[16:0], s_q.prot)) begin
											s_d.pfail = 1'b1;
											s_d.write_latch = 1'b0;
										end else begin
											s_d.op = OP_PROG;
											s_d.cnt = 20'(PROG_CYC - 1);
										end
									end
								end
								OPC_ERASE: begin
									s_d.ph = PH_SKIP;
									s_d.row = nxt[16:0];
									if (s_q.write_latch) begin
										s_d.efail = 1'b0;
										if (s_q.otp_en
											|| row_locked(nxt[16:0], s_q.prot)) begin
											s_d.efail = 1'b1;
											s_d.write_latch = 1'b0;
										end else begin
											s_d.op = OP_ERASE;
											s_d.cnt = 20'(ERASE_CYC - 1);
										end
									end
								end
								OPC_PLOAD, OPC_RLOAD: begin
									s_d.col = nxt[11:0];
									s_d.ph = PH_IN;
									s_d.lanes = 3'd1;
								end
								OPC_PLOAD4, OPC_RLOAD4A, OPC_RLOAD4B: begin
									s_d.col = nxt[11:0];
									s_d.ph = PH_IN;
									s_d.lanes = 3'd4;
								end
								OPC_RD4: begin
									s_d.col = nxt[19:8];
									s_d.ph = PH_OUT;
									s_d.lanes = 3'd4;
								end
								OPC_RD2, OPC_RD2IO: begin
									s_d.col = nxt[19:8];
									s_d.ph = PH_OUT;
									s_d.lanes = 3'd2;
								end
								default: begin
									s_d.col = nxt[19:8];
									s_d.ph = PH_OUT;
									s_d.lanes = 3'd1;
								end
							endcase
						end
					end
					PH_IN: begin
						if (s_q.opc == OPC_SETF) begin
							s_d.ph = PH_SKIP;
							din = byte_in;
							if (s_q.fadr == FA_PROT && !(s_q.prot[GUARD_BIT]
								&& !s_q.ln_s[2])) begin
								s_d.prot = din & PROT_MASK;
							end
							if (s_q.fadr == FA_CFG) begin
								s_d.prt_req = din[CFG_LOCK_BIT];
								s_d.otp_en = din[CFG_OTPEN_BIT];
								s_d.ecc = din[CFG_ECC_BIT];
								s_d.quad = din[CFG_QUAD_BIT];
							end
							if (s_q.fadr == FA_DRV) begin
								s_d.drv = din[6:5];
							end
						end else if (s_q.col <= last_col) begin
							s_d.mem_we = 1'b1;
							s_d.mem_wa = s_q.col;
							s_d.mem_wd = byte_in;
							s_d.col = s_q.col + 12'd1;
						end
					end
					default: s_d.ph = s_q.ph;
				endcase
			end
		end else if (fall && s_q.ph == PH_OUT) begin
			// Output on the falling edge, next byte from cache or feature
			if (s_q.ocnt == 4'd0) begin
				take = (s_q.opc == OPC_GETF) ? feat : mem_rdata;
				if (s_q.opc != OPC_GETF) begin
					s_d.col = s_q.col + 12'd1;
				end
			end else begin
				take = s_q.ob;
			end
			unique case (s_q.lanes)
				3'd4: begin
					s_d.dout = take[7:4];
					s_d.doe = 4'b1111;
				end
				3'd2: begin
					s_d.dout = {2'b00, take[7:6]};
					s_d.doe = 4'b0011;
				end
				default: begin
					s_d.dout = {2'b00, take[7], 1'b0};
					s_d.doe = 4'b0010;
				end
			endcase
			s_d.ob = take << s_q.lanes;
			sum = s_q.ocnt + 4'(s_q.lanes);
			s_d.ocnt = (sum == 4'd8) ? 4'd0 : sum;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.cs_s <= 2'b11;
			s_q.ph <= PH_OPC;
			s_q.lanes <= 3'd1;
			s_q.prot <= PROT_RESET;
			s_q.ecc <= CFG_ECC_RESET;
			s_q.op <= OP_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign serial_line0_o = s_q.dout[0];
	assign serial_line1_o = s_q.dout[1];
	assign serial_line2_o = s_q.dout[2];
	assign serial_line3_o = s_q.dout[3];
	assign serial_line0_oe = s_q.doe[0];
	assign serial_line1_oe = s_q.doe[1];
	assign serial_line2_oe = s_q.doe[2];
	assign serial_line3_oe = s_q.doe[3];
	assign wb_dat_o = s_q.wb_dat;
	assign wb_ack_o = s_q.wb_ack;
endmodule

// ### core/snp_pkg.sv
// Constants, encodings and state types of the serial NAND program/erase
// and protection sequencer. Assumes a 20 MHz system clock.
//
// Functional notes
// - Program execute: opcode then 24-bit row.
// - Execute moves cache to array, busy, polls served.
// - Random load: opcode, dummy nibble, 12-bit column.
// - Random loads only inside data move; cache kept.
// - Quad random loads need quad enable bit set.
// - Last load byte 2175, or 2111 with ECC.
// - Block erase: opcode, 24-bit row, one block.
// - Erase ignored unless write latch set.
// - Cache reads still served during an erase.
// - Soft reset aborts every operation, returns idle.
// - Busy flag valid from 300 ns after reset.
// - Four OTP pages, programmed and read normally.
// - OTP enable steers program and read to OTP.
// - Enable+protect, write enable, execute locks OTP forever.
// - Locked OTP only readable; OTP never erasable.
// - Power-up: range bits all one, others cleared.
// - Guard bit with write-protect low freezes lock bits.
// - Locked target: no busy, fail status 04h/08h.
// - Range code decodes upper/lower, invert, complement.
// - Program ignored without prior write enable.
// - Busy flag set while program, read, erase, reset.
// - Program fail cleared at execute and reset.
package snp_pkg;
	// Opcodes
	localparam logic [7:0] OPC_WREN = 8'h06;
	localparam logic [7:0] OPC_WRDI = 8'h04;
	localparam logic [7:0] OPC_GETF = 8'h0f;
	localparam logic [7:0] OPC_SETF = 8'h1f;
	localparam logic [7:0] OPC_PREAD = 8'h13;
	localparam logic [7:0] OPC_RD = 8'h03;
	localparam logic [7:0] OPC_RDF = 8'h0b;
	localparam logic [7:0] OPC_RD2 = 8'h3b;
	localparam logic [7:0] OPC_RD4 = 8'h6b;
	localparam logic [7:0] OPC_RD2IO = 8'hbb;
	localparam logic [7:0] OPC_PLOAD = 8'h02;
	localparam logic [7:0] OPC_PLOAD4 = 8'h32;
	localparam logic [7:0] OPC_RLOAD = 8'h84;
	localparam logic [7:0] OPC_RLOAD4A = 8'hc4;
	localparam logic [7:0] OPC_RLOAD4B = 8'h34;
	localparam logic [7:0] OPC_PEXE = 8'h10;
	localparam logic [7:0] OPC_ERASE = 8'hd8;
	localparam logic [7:0] OPC_RESET = 8'hff;
	// Feature addresses
	localparam logic [7:0] FA_PROT = 8'ha0;
	localparam logic [7:0] FA_CFG = 8'hb0;
	localparam logic [7:0] FA_STAT = 8'hc0;
	localparam logic [7:0] FA_DRV = 8'hd0;
	// Protection byte: guard 7, range 5..3, lower 2, complement 1
	localparam int GUARD_BIT = 7;
	localparam int LOWER_BIT = 2;
	localparam int COMPL_BIT = 1;
	localparam logic [7:0] PROT_MASK = 8'hbe;
	localparam logic [7:0] PROT_RESET = 8'h38;
	// Configuration byte positions
	localparam int CFG_LOCK_BIT = 7;
	localparam int CFG_OTPEN_BIT = 6;
	localparam int CFG_ECC_BIT = 4;
	localparam int CFG_QUAD_BIT = 0;
	localparam logic CFG_ECC_RESET = 1'b1;
	// Array geometry
	localparam logic [11:0] LAST_COL_RAW = 12'd2175;
	localparam logic [11:0] LAST_COL_ECC = 12'd2111;
	localparam int CACHE_DEPTH = 2176;
	localparam logic [16:0] OTP_PAGES = 17'd4;
	localparam logic [16:0] RANGE_UNIT = 17'h00800;
	// Timing
	localparam int CLK_NS = 50;
	localparam int PROG_TIME_US = 400;
	localparam int ERASE_TIME_US = 3000;
	localparam int READ_TIME_US = 80;
	localparam int RST_TIME_NS = 300;
	localparam int READ_CYC = READ_TIME_US * 1000 / CLK_NS;
	localparam int RST_CYC = (RST_TIME_NS + CLK_NS - 1) / CLK_NS;
	// Register offsets
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_FEAT = 8'h04;
	localparam logic [7:0] REG_ROW = 8'h08;
	localparam logic [7:0] REG_CTRL = 8'h0c;
	localparam logic [7:0] REG_OPINFO = 8'h10;

	// Frame phase
	typedef enum logic [4:0] {
		PH_OPC = 5'b00001,
		PH_HEAD = 5'b00010,
		PH_IN = 5'b00100,
		PH_OUT = 5'b01000,
		PH_SKIP = 5'b10000
	} snp_phase_t;

	// Internal array operation
	typedef enum logic [4:0] {
		OP_IDLE = 5'b00001,
		OP_PROG = 5'b00010,
		OP_READ = 5'b00100,
		OP_ERASE = 5'b01000,
		OP_RST = 5'b10000
	} snp_op_t;

	// Whole state of the core
	typedef struct packed {
		logic [1:0] cs_s;
		logic [1:0] sck_s;
		logic sck_prev;
		logic [3:0] ln_m;
		logic [3:0] ln_s;
		snp_phase_t ph;
		logic [2:0] lanes;
		logic [7:0] opc;
		logic [7:0] sh;
		logic [3:0] bcnt;
		logic [1:0] hd;
		logic [23:0] addr;
		logic [11:0] col;
		logic [7:0] fadr;
		logic [7:0] ob;
		logic [3:0] ocnt;
		logic [3:0] dout;
		logic [3:0] doe;
		logic [7:0] prot;
		logic quad;
		logic ecc;
		logic otp_en;
		logic prt_req;
		logic otp_locked;
		logic [1:0] drv;
		logic write_latch;
		logic pfail;
		logic efail;
		logic idm;
		snp_op_t op;
		logic [19:0] cnt;
		logic [16:0] row;
		logic wb_ack;
		logic [31:0] wb_dat;
		logic mem_we;
		logic [11:0] mem_wa;
		logic [7:0] mem_wd;
	} snp_state_t;
endpackage

// ### testbench/snp_core_assertions.sv
// Checker on the sequencer's bus and link ports.
// Assumes it is bound to snp_core and sees only its ports.
`timescale 1ns/1ps
module snp_core_assertions
	import snp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link
	input wire logic cs_n,
	input wire logic serial_line1_oe,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic rd_q; // Read taken at last edge
	logic [5:0] adr_q; // Its word address
	logic seen_q; // Any frame or write since reset
	logic lock_q; // Area lock once read back set
	logic st_rd, ft_rd, ct_rd;
	assign st_rd = wb_ack_o && rd_q && adr_q == REG_STATUS[7:2];
	assign ft_rd = wb_ack_o && rd_q && adr_q == REG_FEAT[7:2];
	assign ct_rd = wb_ack_o && rd_q && adr_q == REG_CTRL[7:2];
	////////////////////////////////////////////////////////////////////
	// Helper flags
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_q <= 1'b0;
			adr_q <= 6'h00;
			seen_q <= 1'b0;
			lock_q <= 1'b0;
		end else begin
			rd_q <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
			adr_q <= wb_adr_i[7:2];
			seen_q <= seen_q || !cs_n || (wb_cyc_i && wb_we_i);
			lock_q <= lock_q || (ct_rd && wb_dat_o[0]);
		end
	end
	////////////////////////////////////////////////////////////////////
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_next_edge: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack not one cycle after request");
	a_ack_has_req: assert property (
		$rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_status_upper_zero: assert property (st_rd |-> wb_dat_o[31:4] == 0)
		else $error("status upper bits set");
	a_feat_reserved: assert property (ft_rd |-> wb_dat_o[0] == 1'b0 &&
		wb_dat_o[13] == 1'b0 && wb_dat_o[11:9] == 3'h0)
		else $error("reserved feature bits set");
	a_power_up_lock: assert property (
		ft_rd && !seen_q |-> wb_dat_o[15:0] == 16'h1038)
		else $error("power-up protection wrong");
	a_lock_sticky: assert property (ct_rd && lock_q |-> wb_dat_o[0])
		else $error("area lock cleared");
	a_lock_mirror: assert property (ft_rd && lock_q |-> wb_dat_o[15])
		else $error("lock missing in config");
	a_idle_quiet: assert property (cs_n [*8] |-> !serial_line1_oe)
		else $error("line driven while deselected");
	a_drive_in_frame: assert property ($rose(serial_line1_oe) |-> !cs_n)
		else $error("drive began outside frame");
	// Main scenarios reached
	c_lock_read: cover property (ct_rd && wb_dat_o[0]);
	c_busy_read: cover property (st_rd && wb_dat_o[0]);
	c_line_out: cover property ($rose(serial_line1_oe));
endmodule
bind snp_core snp_core_assertions snp_core_assertions_i (.clk(clk),
	.rst(rst), .cs_n(cs_n), .serial_line1_oe(serial_line1_oe),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// ### testbench/snp_core_tb_top.sv
// Self-checking bench for the serial NAND sequencer.
// Assumes short program and erase counts set below.
`timescale 1ns/1ps
module snp_core_tb_top
	import snp_pkg::*;
();
	logic clk, rst, cyc, stb, we, ack, cs_n, sclk;
	logic [7:0] adr, s;
	logic [3:0] sel, ho, hoe, dout, doe, ln;
	logic [31:0] wdat, rdat, rd;
	int failures, checks_done, cycles, c0;
	// Lock code table: {locked, protection byte, row}
	logic [25:0] pt[6] = '{{1'b0, 8'h00, 17'h1ffff},
		{1'b1, 8'h08, 17'h1f800}, {1'b0, 8'h08, 17'h1f7c0},
		{1'b1, 8'h0c, 17'h007c0}, {1'b1, 8'h32, 17'h0003f},
		{1'b0, 8'h32, 17'h00040}};
	// Wire level from all drivers, pulled up when free
	assign ln = (doe & dout) | (~doe & hoe & ho) | (~doe & ~hoe);
	snp_core #(.PROG_CYC(2000), .ERASE_CYC(3000)) snp_core_i (.clk(clk),
		.rst(rst), .cs_n(cs_n), .sclk(sclk), .serial_line0_i(ln[0]),
		.serial_line0_o(dout[0]), .serial_line0_oe(doe[0]),
		.serial_line1_i(ln[1]), .serial_line1_o(dout[1]),
		.serial_line1_oe(doe[1]), .serial_line2_i(ln[2]),
		.serial_line2_o(dout[2]), .serial_line2_oe(doe[2]),
		.serial_line3_i(ln[3]), .serial_line3_o(dout[3]),
		.serial_line3_oe(doe[3]), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack));
	snp_host_model snp_host_model_i (.clk(clk), .cs_n(cs_n), .sclk(sclk),
		.ho(ho), .hoe(hoe), .li(ln));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			failures++;
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// Classic single bus cycle
	task automatic wb(input logic w, input logic [7:0] a);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		do @(posedge clk); while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic f(input logic [7:0] tx[$], input int q = 99,
		input int n = 0);
		snp_host_model_i.frame(tx, q, n);
		s = (n > 0) ? snp_host_model_i.rxq[0] : s;
	endtask
	task automatic st(input logic [7:0] fa);
		f('{OPC_GETF, fa}, 99, 1);
	endtask
	task automatic sf(input logic [7:0] fa, input logic [7:0] v);
		f('{OPC_SETF, fa, v});
	endtask
	task automatic r3(input logic [7:0] op, input logic [23:0] r);
		f('{op, r[23:16], r[15:8], r[7:0]});
	endtask
	task automatic rc(input logic [11:0] c);
		f('{OPC_RD, {4'h0, c[11:8]}, c[7:0], 8'h00}, 99, 1);
	endtask
	// Write enable then execute
	task automatic wx(input logic [7:0] op, input logic [23:0] r);
		f('{OPC_WREN});
		r3(op, r);
		st(FA_STAT);
	endtask
	task automatic poll;
		repeat (60) begin
			st(FA_STAT);
			if (s[0] === 1'b0) break;
		end
	endtask
	task automatic complete_run;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		{rst, cyc, stb, we, adr, sel, wdat} = {3'b100, 45'h0};
		{failures, checks_done, cycles} = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		sel <= 4'hf;
		repeat (4) @(posedge clk);
		wb(1'b0, REG_FEAT); chk(rd, 32'h1038);
		st(FA_PROT); chk(s, 8'h38);
		wb(1'b1, 8'h1c); wb(1'b0, 8'h1c); chk(rd, 0);
		f('{OPC_PLOAD, 8'h00, 8'h00, 8'ha5, 8'h3c});
		r3(OPC_PEXE, 24'h40); st(FA_STAT); chk(s, 0);
		r3(OPC_ERASE, 24'h40); st(FA_STAT); chk(s, 0);
		wx(OPC_ERASE, 24'h40); chk(s, 8'h04);
		wx(OPC_PEXE, 24'h05); chk(s, 8'h0c);
		// Erase fail stands until reset, clear it before timing a program
		f('{OPC_RESET});
		sf(FA_PROT, 8'h00);
		c0 = cycles;
		wx(OPC_PEXE, 24'h05); chk({s[3], s[0]}, 1);
		wb(1'b0, REG_STATUS); chk(rd[0], 1);
		while (rd[0] === 1'b1) wb(1'b0, REG_STATUS);
		// Enable and execute frames take about 331 clocks before busy
		chk(cycles - c0 > 2300 && cycles - c0 < 2400, 1);
		poll(); chk(s, 0);
		foreach (pt[k]) begin
			sf(FA_PROT, pt[k][24:17]);
			wx(OPC_ERASE, {7'h00, pt[k][16:0]});
			chk({s[2], s[0]}, pt[k][25] ? 2 : 1);
			f('{OPC_RESET});
			st(FA_STAT); chk(s, 0);
		end
		sf(FA_PROT, 8'h00);
		wx(OPC_ERASE, 24'h80); chk(s[0], 1);
		rc(12'h000); chk(s, 8'ha5);
		poll(); chk(s, 0);
		f('{OPC_RLOAD, 8'h00, 8'h01, 8'h77});
		rc(12'h001); chk(s, 8'h3c);
		r3(OPC_PREAD, 24'h05); poll();
		f('{OPC_RLOAD, 8'h00, 8'h01, 8'h77, 8'h88});
		rc(12'h001); chk(s, 8'h77);
		rc(12'h002); chk(s, 8'h88);
		f('{OPC_RLOAD4A, 8'h00, 8'h00, 8'h5a}, 3);
		rc(12'h000); chk(s, 8'ha5);
		sf(FA_CFG, 8'h11);
		f('{OPC_RLOAD4B, 8'h00, 8'h04, 8'h5a}, 3);
		rc(12'h004); chk(s, 8'h5a);
		f('{OPC_RLOAD, 8'h08, 8'h3f, 8'h11, 8'h22});
		rc(12'h83f); chk(s, 8'h11);
		wx(OPC_PEXE, 24'h05); chk(s[0], 1);
		poll();
		sf(FA_PROT, 8'h80);
		snp_host_model_i.wp_low = 1'b1;
		sf(FA_PROT, 8'h00); st(FA_PROT); chk(s, 8'h80);
		snp_host_model_i.wp_low = 1'b0;
		sf(FA_PROT, 8'h00); st(FA_PROT); chk(s, 8'h00);
		sf(FA_CFG, 8'h50);
		wx(OPC_PEXE, 24'h04); chk(s, 8'h08);
		wx(OPC_PEXE, 24'h03); chk(s[0], 1);
		poll();
		wx(OPC_ERASE, 24'h00); chk(s, 8'h04);
		sf(FA_CFG, 8'hd0);
		wx(OPC_PEXE, 24'h00); poll();
		wb(1'b0, REG_CTRL); chk(rd[0], 1);
		sf(FA_CFG, 8'h10); st(FA_CFG); chk(s[7], 1);
		sf(FA_CFG, 8'h50);
		wx(OPC_PEXE, 24'h01); chk(s, 8'h0c);
		complete_run();
	end
endmodule

// ### testbench/snp_host_model.sv
// Host side of the serial link, mode 0, MSB first.
// Assumes clk is the system clock; sclk half period is four clk.
`timescale 1ns/1ps
module snp_host_model (
	// Clock
	input wire logic clk,
	// Link pins
	output logic cs_n,
	output logic sclk,
	output logic [3:0] ho,
	output logic [3:0] hoe,
	input wire logic [3:0] li
);
	logic wp_low; // Hold line2 low as write-protect
	logic [7:0] rxq[$]; // Bytes read back
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		ho = 4'h0;
		hoe = 4'h0;
		wp_low = 1'b0;
	end
	// Wait n system clocks
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Frame: tx bytes, quad from index q4, then n bytes on line1
	task automatic frame(input logic [7:0] tx[$], input int q4,
		input int n);
		logic [7:0] b;
		int w;
		rxq = {};
		cs_n <= 1'b0;
		foreach (tx[k]) begin
			w = (k >= q4) ? 4 : 1;
			hoe <= (w == 4) ? 4'hf : {1'b0, wp_low, 2'b01};
			for (int i = 8 - w; i >= 0; i -= w) begin
				ho <= (w == 4) ? tx[k][i+:4] : {3'b000, tx[k][i]};
				tk(4);
				sclk <= 1'b1;
				tk(4);
				sclk <= 1'b0;
			end
		end
		// Released lines fall to their pull-ups
		hoe <= {1'b0, wp_low, 2'b00};
		repeat (n) begin
			for (int i = 0; i < 8; i++) begin
				tk(4);
				sclk <= 1'b1;
				tk(4);
				b = {b[6:0], li[1]};
				sclk <= 1'b0;
			end
			rxq.push_back(b);
		end
		tk(4);
		cs_n <= 1'b1;
		hoe <= 4'h0;
		tk(8);
	endtask
endmodule
